// *** dsi_pkg.sv ***
package dsi_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int INIT_WAIT_US       = 200;
  localparam int INIT_WAIT_CYC      = (INIT_WAIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int MODE_GAP_CYC       = 2;
  localparam int MIN_REFRESH_CNT    = 2;
  localparam int SETTLE_CYC         = 200;
  localparam int ROW_CYCLE_NS       = 65;
  localparam int ROW_CYCLE_CYC      =
    (ROW_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXIT_SETUP_CYC     = 1;
  localparam int CNT_W              = 16;
  // ==========================================================
  // bus widths and field positions
  localparam int ADDR_W             = 13;
  localparam int BANK_W             = 2;
  localparam int DLL_OFF_BIT        = 0;
  localparam int DLL_RESET_BIT      = 8;
  localparam int BL_LSB             = 0;
  localparam int BT_BIT             = 3;
  localparam logic [1:0] BANK_MODE  = 2'h0;
  localparam logic [1:0] BANK_EXT   = 2'h1;
  localparam logic [2:0] BL_CODE_2  = 3'h1;
  localparam logic [2:0] BL_CODE_4  = 3'h2;
  localparam logic [2:0] BL_CODE_8  = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_RESET_VAL = 13'h0000;
  // ==========================================================
  // commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESEL  = 4'h8;
  localparam logic [3:0] CMD_NOP    = 4'h7;
  localparam logic [3:0] CMD_PRE    = 4'h2;
  localparam logic [3:0] CMD_REF    = 4'h1;
  localparam logic [3:0] CMD_MODE   = 4'h0;
  localparam logic [3:0] CMD_ACT    = 4'h3;
  localparam logic [3:0] CMD_READ   = 4'h5;
  localparam logic [3:0] CMD_WRITE  = 4'h4;
  localparam int A10_BIT            = 10;
  // ==========================================================
  // controller software registers
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_EMODE  = 4'h2;
  localparam logic [3:0] REG_MODE   = 4'h3;
  localparam int CTRL_START_BIT     = 0;
  localparam int CTRL_PD_BIT        = 1;
  localparam int CTRL_SR_BIT        = 2;
  localparam logic [ADDR_W-1:0] EMODE_RESET_VAL = 13'h0000;
  localparam logic [ADDR_W-1:0] MODE_INIT_VAL   = 13'h0032;

  typedef enum logic [2:0] {
    DSI_DEV_POWERUP, DSI_DEV_IDLE, DSI_DEV_MODEGAP, DSI_DEV_PD,
    DSI_DEV_SR, DSI_DEV_SREXIT, DSI_DEV_SUSP
  } dsi_dev_e;
endpackage : dsi_pkg

// *** dsi_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface dsi_if;
  logic        cke;
  logic [3:0]  cmd;
  logic [12:0] addr;
  logic [1:0]  bank;
  logic        ready;
  logic        dll_on;
  modport dev  (input cke, cmd, addr, bank, output ready, dll_on);
  modport ctrl (output cke, cmd, addr, bank, input ready, dll_on);
endinterface : dsi_if
`default_nettype wire

// *** dsi_dev.sv ***
`timescale 1ns/10ps
`default_nettype none
module dsi_dev (
  input  wire logic        clk,
  input  wire logic        resetn,
  dsi_if.dev               lnk,
  input  wire logic [2:0]  beat,
  output logic [2:0]       col_low,
  output logic             dev_ready,
  output logic             dll_enabled,
  output logic [12:0]      mode_value
);
  typedef struct packed {
    dsi_pkg::dsi_dev_e      st;
    logic [dsi_pkg::CNT_W-1:0] cnt;
    logic                   cke_d;
    logic [12:0]            emode;
    logic [12:0]            mode;
    logic                   dll_rst;
    logic                   ready;
    logic [2:0]             col;
    logic [2:0]             start;
    logic                   dll;
    dsi_pkg::dsi_dev_e      susp_st;
  } dsi_dev_s;

  dsi_dev_s s_reg;
  dsi_dev_s s_next;

  // ==========================================================
  // burst column order
  function automatic logic [2:0] col_of(input logic [2:0] st,
                                        input logic [2:0] bt,
                                        input logic       ilv,
                                        input logic [2:0] blc);
    logic [2:0] msk;
    logic [2:0] raw;
    msk = (blc == dsi_pkg::BL_CODE_2) ? 3'h1 :
          (blc == dsi_pkg::BL_CODE_4) ? 3'h3 : 3'h7;
    raw = ilv ? (st ^ bt) : 3'(st + bt);
    col_of = (st & ~msk) | (raw & msk);
  endfunction : col_of

  // ==========================================================
  // command decode, shared by power-up and idle handling
  function automatic logic is_cmd(input logic       ck,
                                  input logic [3:0] c,
                                  input logic [3:0] want);
    is_cmd = ck && (c == want);
  endfunction : is_cmd

  logic cke_fall;
  logic mode_cmd;
  logic ref_cmd;
  logic rw_cmd;
  // a falling clock gate is seen against the previous sample
  always_comb begin
    cke_fall = s_reg.cke_d && !lnk.cke;
    mode_cmd = is_cmd(lnk.cke, lnk.cmd, dsi_pkg::CMD_MODE);
    ref_cmd  = is_cmd(lnk.cke, lnk.cmd, dsi_pkg::CMD_REF);
    rw_cmd   = is_cmd(lnk.cke, lnk.cmd, dsi_pkg::CMD_READ) ||
               is_cmd(lnk.cke, lnk.cmd, dsi_pkg::CMD_WRITE);
  end

  // ==========================================================
  // state update
  always_comb begin
    s_next = s_reg;
    s_next.cke_d = lnk.cke;
    if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
    case (s_reg.st)
      dsi_pkg::DSI_DEV_POWERUP: begin
        if (mode_cmd) begin
          if (lnk.bank == dsi_pkg::BANK_MODE) begin
            s_next.mode = lnk.addr;
            s_next.dll_rst = 1'b1;
          end else if (lnk.bank == dsi_pkg::BANK_EXT) begin
            s_next.emode = lnk.addr;
          end
        end
        if (ref_cmd) begin
          s_next.cnt = dsi_pkg::CNT_W'(dsi_pkg::SETTLE_CYC);
          s_next.dll_rst = 1'b0;
        end else if (s_reg.cnt == 16'h0001) begin
          s_next.st = dsi_pkg::DSI_DEV_IDLE;
          s_next.ready = 1'b1;
        end
      end
      dsi_pkg::DSI_DEV_IDLE: begin
        if (cke_fall) begin
          if (lnk.cmd == dsi_pkg::CMD_REF) begin
            s_next.st = dsi_pkg::DSI_DEV_SR;
          end else begin
            s_next.st = dsi_pkg::DSI_DEV_PD;
          end
          s_next.ready = 1'b0;
        end else if (mode_cmd) begin
          if (lnk.bank == dsi_pkg::BANK_EXT) begin
            s_next.emode = lnk.addr;
          end else if (lnk.bank == dsi_pkg::BANK_MODE) begin
            s_next.mode = lnk.addr;
          end
          s_next.st = dsi_pkg::DSI_DEV_MODEGAP;
          s_next.cnt = dsi_pkg::CNT_W'(dsi_pkg::MODE_GAP_CYC - 1);
          s_next.ready = 1'b0;
        end else if (rw_cmd) begin
          s_next.start = lnk.addr[2:0];
        end
      end
      dsi_pkg::DSI_DEV_MODEGAP: begin
        if (cke_fall) begin
          s_next.susp_st = s_reg.st;
          s_next.st = dsi_pkg::DSI_DEV_SUSP;
        end else if (s_reg.cnt <= 16'h0001) begin
          s_next.st = dsi_pkg::DSI_DEV_IDLE;
          s_next.ready = 1'b1;
        end
      end
      dsi_pkg::DSI_DEV_PD: begin
        if (lnk.cke) begin
          s_next.st = dsi_pkg::DSI_DEV_IDLE;
          s_next.ready = 1'b1;
        end
      end
      dsi_pkg::DSI_DEV_SUSP: begin
        // clock stopped, so the mode-gap or self-refresh exit count freezes
        s_next.cnt = s_reg.cnt;
        if (lnk.cke) begin
          s_next.st = s_reg.susp_st;
        end
      end
      dsi_pkg::DSI_DEV_SR: begin
        if (lnk.cke) begin
          s_next.st = dsi_pkg::DSI_DEV_SREXIT;
          s_next.cnt = dsi_pkg::CNT_W'(dsi_pkg::ROW_CYCLE_CYC);
        end
      end
      dsi_pkg::DSI_DEV_SREXIT: begin
        if (cke_fall) begin
          s_next.susp_st = s_reg.st;
          s_next.st = dsi_pkg::DSI_DEV_SUSP;
        end else if (s_reg.cnt <= 16'h0001) begin
          s_next.st = dsi_pkg::DSI_DEV_IDLE;
          s_next.ready = 1'b1;
        end
      end
      default: begin
        s_next.st = dsi_pkg::DSI_DEV_POWERUP;
      end
    endcase
    s_next.col = col_of(s_reg.start, beat, s_reg.mode[dsi_pkg::BT_BIT],
                        s_reg.mode[2:0]);
    s_next.dll = !s_next.emode[dsi_pkg::DLL_OFF_BIT] && !s_next.dll_rst;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{st: dsi_pkg::DSI_DEV_POWERUP, cnt: '0, cke_d: 1'b0,
                 emode: dsi_pkg::EMODE_RESET_VAL,
                 mode: dsi_pkg::MODE_RESET_VAL, dll_rst: 1'b0,
                 ready: 1'b0, col: 3'h0, start: 3'h0,
                 dll: !dsi_pkg::EMODE_RESET_VAL[dsi_pkg::DLL_OFF_BIT],
                 susp_st: dsi_pkg::DSI_DEV_POWERUP};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign col_low     = s_reg.col;
  assign dev_ready   = s_reg.ready;
  assign mode_value  = s_reg.mode;
  assign dll_enabled = s_reg.dll;
  assign lnk.ready   = s_reg.ready;
  assign lnk.dll_on  = s_reg.dll;
endmodule : dsi_dev
`default_nettype wire

// *** dsi_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module dsi_ctrl #(
  parameter int INIT_WAIT = dsi_pkg::INIT_WAIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  dsi_if.ctrl              lnk,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [15:0]      sw_rdata
);
  typedef enum logic [3:0] {
    C_OFF, C_WAIT, C_PRE, C_EXT, C_GAP1, C_MODE, C_GAP2,
    C_REF, C_REFGAP, C_SETTLE, C_RUN, C_LOW, C_WAKE
  } dsi_ctrl_e;
  typedef struct packed {
    dsi_ctrl_e   st;
    logic [31:0] cnt;
    logic [1:0]  refs;
    logic        cke;
    logic [3:0]  cmd;
    logic [12:0] addr;
    logic [1:0]  bank;
    logic [12:0] emode;
    logic [12:0] mode;
    logic        pd_req;
    logic        sr_req;
    logic [15:0] rdata;
  } dsi_ctrl_s;

  dsi_ctrl_s s_reg;
  dsi_ctrl_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.cmd = dsi_pkg::CMD_NOP;
    s_next.addr = '0;
    s_next.bank = '0;
    s_next.rdata = '0;
    if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
    if (sw_wr) begin
      case (sw_addr)
        dsi_pkg::REG_CTRL: begin
          s_next.pd_req = sw_wdata[dsi_pkg::CTRL_PD_BIT];
          s_next.sr_req = sw_wdata[dsi_pkg::CTRL_SR_BIT];
        end
        dsi_pkg::REG_EMODE: s_next.emode = sw_wdata[12:0];
        dsi_pkg::REG_MODE:  s_next.mode = sw_wdata[12:0];
        default: ;
      endcase
    end
    if (sw_rd) begin
      case (sw_addr)
        dsi_pkg::REG_STATUS: s_next.rdata = {8'h00, 4'(s_reg.st),
                                             2'h0, lnk.dll_on, lnk.ready};
        dsi_pkg::REG_EMODE:  s_next.rdata = {3'h0, s_reg.emode};
        dsi_pkg::REG_MODE:   s_next.rdata = {3'h0, s_reg.mode};
        default:             s_next.rdata = 16'h0000;
      endcase
    end
    case (s_reg.st)
      C_OFF: begin
        if (sw_wr && sw_addr == dsi_pkg::REG_CTRL &&
            sw_wdata[dsi_pkg::CTRL_START_BIT]) begin
          s_next.st = C_WAIT;
          s_next.cke = 1'b1;
          s_next.cnt = 32'(INIT_WAIT);
        end
      end
      C_WAIT: if (s_reg.cnt <= 32'h1) s_next.st = C_PRE;
      C_PRE: begin
        s_next.cmd = dsi_pkg::CMD_PRE;
        s_next.addr[dsi_pkg::A10_BIT] = 1'b1;
        s_next.st = C_EXT;
      end
      C_EXT: begin
        s_next.cmd = dsi_pkg::CMD_MODE;
        s_next.bank = dsi_pkg::BANK_EXT;
        s_next.addr = s_reg.emode;
        s_next.cnt = 32'(dsi_pkg::MODE_GAP_CYC);
        s_next.st = C_GAP1;
      end
      C_GAP1: if (s_reg.cnt <= 32'h1) s_next.st = C_MODE;
      C_MODE: begin
        s_next.cmd = dsi_pkg::CMD_MODE;
        s_next.bank = dsi_pkg::BANK_MODE;
        s_next.addr = s_reg.mode;
        s_next.addr[dsi_pkg::DLL_RESET_BIT] = 1'b1;
        s_next.cnt = 32'(dsi_pkg::MODE_GAP_CYC);
        s_next.st = C_GAP2;
      end
      C_GAP2: if (s_reg.cnt <= 32'h1) s_next.st = C_REF;
      C_REF: begin
        s_next.cmd = dsi_pkg::CMD_REF;
        s_next.refs = s_reg.refs + 1'b1;
        s_next.cnt = 32'(dsi_pkg::ROW_CYCLE_CYC);
        s_next.st = C_REFGAP;
      end
      C_REFGAP: begin
        if (s_reg.cnt <= 32'h1) begin
          if (s_reg.refs >= 2'(dsi_pkg::MIN_REFRESH_CNT)) begin
            s_next.st = C_SETTLE;
            s_next.cnt = 32'(dsi_pkg::SETTLE_CYC + 1);
          end else begin
            s_next.st = C_REF;
          end
        end
      end
      C_SETTLE: if (lnk.ready && s_reg.cnt == '0) s_next.st = C_RUN;
      C_RUN: begin
        if ((s_reg.pd_req || s_reg.sr_req) && lnk.ready) begin
          s_next.cke = 1'b0;
          s_next.cmd = s_reg.sr_req ? dsi_pkg::CMD_REF : dsi_pkg::CMD_NOP;
          s_next.st = C_LOW;
        end
      end
      C_LOW: begin
        if (!s_reg.pd_req && !s_reg.sr_req) begin
          s_next.cke = 1'b1;
          s_next.cnt = 32'(dsi_pkg::ROW_CYCLE_CYC + dsi_pkg::EXIT_SETUP_CYC);
          s_next.st = C_WAKE;
        end
      end
      C_WAKE: if (s_reg.cnt == '0 && lnk.ready) s_next.st = C_RUN;
      default: s_next.st = C_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{st: C_OFF, cnt: '0, refs: '0, cke: 1'b0,
                 cmd: dsi_pkg::CMD_NOP, addr: '0, bank: '0,
                 emode: dsi_pkg::EMODE_RESET_VAL,
                 mode: dsi_pkg::MODE_INIT_VAL, pd_req: 1'b0,
                 sr_req: 1'b0, rdata: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.cke  = s_reg.cke;
  assign lnk.cmd  = s_reg.cmd;
  assign lnk.addr = s_reg.addr;
  assign lnk.bank = s_reg.bank;
  assign sw_rdata = s_reg.rdata;
endmodule : dsi_ctrl
`default_nettype wire

// *** dsi_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module dsi_checker #(
  parameter int INIT_WAIT = 10
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        cke,
  input  wire logic [3:0]  cmd,
  input  wire logic [12:0] addr,
  input  wire logic [1:0]  bank,
  input  wire logic        ready,
  input  wire logic        dll_on
);
  logic [15:0] cyc_reg;
  logic [15:0] quiet_reg;
  logic [1:0]  refs_reg;
  logic        cke_reg;
  logic        sr_reg;
  logic        nop_c;
  logic        ref_c;
  assign nop_c = (cmd == dsi_pkg::CMD_NOP) || (cmd == dsi_pkg::CMD_DESEL);
  assign ref_c = (cmd == dsi_pkg::CMD_REF) && cke;
  // ==========================================================
  // helper counters, saturating so long runs never wrap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cyc_reg   <= '0;
      quiet_reg <= '0;
      refs_reg  <= '0;
      cke_reg   <= 1'b0;
      sr_reg    <= 1'b0;
    end else begin
      cke_reg <= cke;
      if (cyc_reg != 16'hffff) cyc_reg <= cyc_reg + 16'h1;
      if (ref_c) quiet_reg <= '0;
      else if (quiet_reg != 16'hffff) quiet_reg <= quiet_reg + 16'h1;
      if (cmd == dsi_pkg::CMD_MODE) refs_reg <= '0;
      else if (ref_c && refs_reg != 2'h3) refs_reg <= refs_reg + 2'h1;
      if (cke_reg && !cke && cmd == dsi_pkg::CMD_REF) sr_reg <= 1'b1;
      else if (ready) sr_reg <= 1'b0;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_init_wait; !nop_c |-> cyc_reg >= INIT_WAIT; endproperty
  a_init_wait: assert property (p_init_wait)
    else $error("command before power-up wait");
  property p_mode_gap; cmd == dsi_pkg::CMD_MODE |=> nop_c; endproperty
  a_mode_gap: assert property (p_mode_gap)
    else $error("command inside mode-set gap");
  property p_mode_bank; cmd == dsi_pkg::CMD_MODE |-> !bank[1]; endproperty
  a_mode_bank: assert property (p_mode_bank)
    else $error("mode set with bad bank select");
  property p_mode_ready; cmd == dsi_pkg::CMD_MODE |=> !ready; endproperty
  a_mode_ready: assert property (p_mode_ready)
    else $error("ready high after mode set");
  property p_dll_off;
    cmd == dsi_pkg::CMD_MODE && bank == dsi_pkg::BANK_EXT && addr[0]
      |-> ##[1:2] !dll_on;
  endproperty
  a_dll_off: assert property (p_dll_off)
    else $error("dll still on after disable");
  property p_entry;
    $fell(cke) |-> $past(ready) && (nop_c || cmd == dsi_pkg::CMD_REF);
  endproperty
  a_entry: assert property (p_entry)
    else $error("bad low-power entry");
  property p_wake; $rose(cke) |=> nop_c; endproperty
  a_wake: assert property (p_wake)
    else $error("command without exit setup");
  property p_sr_exit; $rose(cke) && sr_reg |-> !ready [*8]; endproperty
  a_sr_exit: assert property (p_sr_exit)
    else $error("ready too soon after self-refresh");
  property p_settle;
    $rose(ready) |-> quiet_reg >= 16'(dsi_pkg::SETTLE_CYC - 1);
  endproperty
  a_settle: assert property (p_settle)
    else $error("ready before settle time");
  property p_refs; $rose(ready) |-> refs_reg >= 2'h2; endproperty
  a_refs: assert property (p_refs)
    else $error("ready with too few refreshes");
endmodule : dsi_checker
`default_nettype wire

// *** ddr_sdram_init_and_mode_setup_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module ddr_sdram_init_and_mode_setup_bench;
  logic        clk;
  logic        resetn;
  logic [3:0]  sw_addr;
  logic [15:0] sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [15:0] sw_rdata;
  logic [2:0]  beat;
  logic [2:0]  col_low;
  logic        dev_ready;
  logic        dll_enabled;
  logic [12:0] mode_value;
  logic [15:0] rv;
  int          failures;
  int          tests_run;
  int          n;
  dsi_if dsi_if_inst ();
  dsi_ctrl #(.INIT_WAIT(10)) dsi_ctrl_inst (.clk(clk), .resetn(resetn),
    .lnk(dsi_if_inst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  dsi_dev dsi_dev_inst (.clk(clk), .resetn(resetn), .lnk(dsi_if_inst),
    .beat(beat), .col_low(col_low), .dev_ready(dev_ready),
    .dll_enabled(dll_enabled), .mode_value(mode_value));
  dsi_checker #(.INIT_WAIT(10)) dsi_checker_inst (.clk(clk),
    .resetn(resetn), .cke(dsi_if_inst.cke), .cmd(dsi_if_inst.cmd),
    .addr(dsi_if_inst.addr), .bank(dsi_if_inst.bank),
    .ready(dsi_if_inst.ready), .dll_on(dsi_if_inst.dll_on));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : check
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_wr    <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_rd   <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read
  // bounded wait; cycle count returned for timing checks
  task automatic wait_ready(input logic lvl, input int lim);
    n = 0;
    while (dsi_if_inst.ready !== lvl && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    check({15'h0, dsi_if_inst.ready}, {15'h0, lvl});
  endtask : wait_ready
  // start held at zero, so both orders give beat modulo length
  task automatic burst(input int bl);
    for (int b = 0; b < 8; b++) begin
      @(posedge clk);
      beat <= 3'(b);
      @(posedge clk);
      #1 check({13'h0, col_low}, 16'(b % bl));
    end
  endtask : burst
  task automatic boot(input logic [15:0] em, input logic [15:0] md);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    sw_write(dsi_pkg::REG_EMODE, em);
    sw_write(dsi_pkg::REG_MODE, md);
    sw_write(dsi_pkg::REG_CTRL, 16'h0001);
    wait_ready(1'b1, 2000);
  endtask : boot
  task automatic summarize();
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #80000;
    failures++;
    summarize();
  end
  initial begin
    failures = 0;
    tests_run = 0;
    resetn = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    beat = 3'h0;
    boot(16'h0000, 16'h0032);
    sw_read(dsi_pkg::REG_STATUS, rv);
    check({14'h0, rv[1:0]}, 16'h0003);
    check({8'h0, mode_value[7:0]}, 16'h0032);
    sw_read(4'hf, rv);
    check(rv, 16'h0000);
    burst(4);
    // power-down entry and exit
    sw_write(dsi_pkg::REG_CTRL, 16'h0003);
    wait_ready(1'b0, 50);
    check({15'h0, dsi_if_inst.cke}, 16'h0000);
    sw_write(dsi_pkg::REG_CTRL, 16'h0001);
    wait_ready(1'b1, 50);
    // self-refresh held long enough to clear settle window
    sw_write(dsi_pkg::REG_CTRL, 16'h0005);
    wait_ready(1'b0, 50);
    repeat (250) @(posedge clk);
    sw_write(dsi_pkg::REG_CTRL, 16'h0001);
    wait_ready(1'b1, 100);
    check(16'(n >= dsi_pkg::ROW_CYCLE_CYC - 1), 16'h0001);
    check({15'h0, dll_enabled}, 16'h0001);
    // second boot mid-run: dll off, interleaved bursts
    boot(16'h0001, 16'h003a);
    sw_read(dsi_pkg::REG_STATUS, rv);
    check({14'h0, rv[1:0]}, 16'h0001);
    check({15'h0, dll_enabled}, 16'h0000);
    burst(4);
    summarize();
  end
endmodule : ddr_sdram_init_and_mode_setup_bench
`default_nettype wire
